// file: smt_pkg.sv
/*
 * smt_pkg: constants, types and command codes for the single-measure and
 * temperature-scan sequencer.
 * assumes: compiled before every other file of the block.
 */
`default_nettype none
package smt_pkg;

  // ************************************************************
  // command codes and element suffixes
  // ************************************************************
  localparam logic [5:0] SMT_OP_MEASURE = 6'h08;
  localparam logic [5:0] SMT_OP_TSCAN   = 6'h0A;
  localparam logic [5:0] SMT_EL_PACK    = 6'h00;
  localparam logic [5:0] SMT_EL_CELL1   = 6'h01;
  localparam logic [5:0] SMT_EL_CELL12  = 6'h0C;
  localparam logic [5:0] SMT_EL_ITEMP   = 6'h10;
  localparam logic [5:0] SMT_EL_EXT1    = 6'h11;
  localparam logic [5:0] SMT_EL_EXT4    = 6'h14;
  localparam logic [5:0] SMT_EL_REF     = 6'h15;
  localparam logic [5:0] SMT_EL_AUXREF  = 6'h16;
  localparam logic [5:0] SMT_EL_LOOP    = 6'h17;

  // ************************************************************
  // result memory layout (index = element suffix)
  // ************************************************************
  localparam int SMT_NELEM  = 24;
  localparam int SMT_AW     = 5;
  localparam int SMT_DW     = 14;
  localparam int SMT_NEXT   = 4;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SMT_CLK_HZ     = 40_000_000;
  localparam int SMT_DWELL_US   = 2500;
  localparam int SMT_DWELL_CYC  = (SMT_CLK_HZ / 1_000_000) * SMT_DWELL_US;

  // ************************************************************
  // ahb register map
  // ************************************************************
  localparam logic [11:0] SMT_A_CMD    = 12'h000;
  localparam logic [11:0] SMT_A_STAT   = 12'h004;
  localparam logic [11:0] SMT_A_CFG    = 12'h008;
  localparam logic [11:0] SMT_A_THR    = 12'h00C;
  localparam logic [11:0] SMT_A_DEVAD  = 12'h010;
  localparam logic [11:0] SMT_A_RES    = 12'h100;
  localparam logic [11:0] SMT_A_RESEND = 12'h15C;
  localparam logic [1:0]  SMT_HT_NONSEQ = 2'b10;
  localparam logic [2:0]  SMT_HS_WORD   = 3'b010;
  localparam int SMT_CMD_START   = 31;
  localparam int SMT_STAT_BUSY   = 0;
  localparam int SMT_STAT_FAULT  = 1;
  localparam int SMT_STAT_NOTE   = 2;
  localparam int SMT_STAT_BIAS   = 3;

  // sequencer states
  typedef enum logic [2:0] {
    SMT_IDLE, SMT_SETTLE, SMT_START, SMT_WAIT, SMT_NEXTEL, SMT_DONE
  } smt_state_type;

  // conversion request toward the analog front end
  typedef struct packed {
    logic                 req;
    logic [5:0]           mux_sel;
  } smt_conv_req_type;

  // conversion answer from the front end
  typedef struct packed {
    logic                 done;
    logic [SMT_DW-1:0]    data;
  } smt_conv_rsp_type;

  // ahb slave request
  typedef struct packed {
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [2:0]           hsize;
    logic                 hready;
  } smt_ahb_req_type;

endpackage : smt_pkg
`default_nettype wire

// file: smt_mem.sv
/*
 * smt_mem: result memory of the sequencer, one word per element.
 * assumes: one writer, one reader, read data registered.
 */
`default_nettype none
module smt_mem
  import smt_pkg::*;
#(
  parameter int AW = SMT_AW,
  parameter int DW = SMT_DW
) (
  input  wire logic          clk_sys, // system clock
  input  wire logic          sys_rst, // async reset, high
  input  wire logic          wr_en,   // write strobe
  input  wire logic [AW-1:0] wr_addr, // write index
  input  wire logic [DW-1:0] wr_data, // write word
  input  wire logic [AW-1:0] rd_addr, // read index
  output logic      [DW-1:0] rd_data  // registered read word
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rd;
  } smt_mem_st_type;

  smt_mem_st_type st_q, st_d;

  // words hold until the same index is written again
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.mem[wr_addr] = wr_data;
    end
    st_d.rd = st_q.mem[rd_addr];
  end

  // registered storage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd;

endmodule : smt_mem
`default_nettype wire

// file: smt_ahb.sv
/*
 * smt_ahb: ahb-lite slave front end, captures the address phase.
 * assumes: single word transfers, zero wait states, always okay.
 */
`default_nettype none
module smt_ahb
  import smt_pkg::*;
(
  input  wire logic            clk_sys,  // system clock
  input  wire logic            sys_rst,  // async reset, high
  input  wire smt_ahb_req_type ahb_in,   // address phase signals
  output logic                 wr_act,   // data phase is a write
  output logic                 rd_act,   // data phase is a read
  output logic [11:0]          act_addr  // latched byte address
);

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
  } smt_ahb_st_type;

  smt_ahb_st_type st_q, st_d;

  // sample a valid word transfer when the bus is ready
  always_comb begin
    st_d = st_q;
    if (ahb_in.hready) begin
      st_d.wr = ahb_in.hsel && (ahb_in.htrans == SMT_HT_NONSEQ)
                && (ahb_in.hsize == SMT_HS_WORD) && ahb_in.hwrite;
      st_d.rd = ahb_in.hsel && (ahb_in.htrans == SMT_HT_NONSEQ)
                && (ahb_in.hsize == SMT_HS_WORD) && !ahb_in.hwrite;
      st_d.addr = ahb_in.haddr[11:0];
    end
  end

  // address phase register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign wr_act   = st_q.wr;
  assign rd_act   = st_q.rd;
  assign act_addr = st_q.addr;

endmodule : smt_ahb
`default_nettype wire

// file: smt_top.sv
/*
 * smt_top: single-element measure and temperature scan sequencer with
 * its ahb-lite register file and result memory.
 * assumes: converter answers each request with one done pulse; bus
 * master issues single word transfers only.
 */
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`default_nettype none
module smt_top
  import smt_pkg::*;
#(
  parameter int DWELL_CYC = SMT_DWELL_CYC, // settling dwell in cycles
  parameter int NEXT      = SMT_NEXT       // external inputs
) (
  input  wire logic             clk_sys,       // 40 MHz clock
  input  wire logic             sys_rst,       // async reset, high
  input  wire logic             hsel,          // ahb select
  input  wire logic [31:0]      haddr,         // ahb address
  input  wire logic [1:0]       htrans,        // ahb transfer type
  input  wire logic             hwrite,        // ahb write
  input  wire logic [2:0]       hsize,         // ahb size
  input  wire logic [31:0]      hwdata,        // ahb write data
  input  wire logic             hready,        // ahb bus ready
  output logic      [31:0]      hrdata,        // ahb read data
  output logic                  hreadyout,     // always ready
  output logic                  hresp,         // always okay
  output logic                  conv_req,      // start conversion
  output logic      [5:0]       conv_sel,      // mux selection
  input  wire logic             conv_done,     // conversion done
  input  wire logic [SMT_DW-1:0] conv_data,    // conversion result
  output logic                  thermistor_bias_output, // bias switch
  output logic      [NEXT-1:0]  ext_pullup_en, // input pull-ups
  output logic                  fault_out,     // fault pin
  output logic                  fault_note     // notify pulse
);

  // one enable per input is wired; the dwell counter holds 23 bits
  if (NEXT != SMT_NEXT || DWELL_CYC < 1 ||
      DWELL_CYC >= (1 << 23)) begin : g_param_check
    $error("smt_top: unsupported parameters");
  end

  // ************************************************************
  // state
  // ************************************************************
  // fsm, cnt and el run the conversions; last marks the final
  // element of the run, scan tells a scan from a single measure;
  // fpend holds a fault until the run ends, fault and note report it;
  // req and bias drive the front end; the rest is the register file that software reads and writes
  typedef struct packed {
    smt_state_type         fsm;
    logic [22:0]           cnt;
    logic [5:0]            el;
    logic [5:0]            last;
    logic                  scan;
    logic                  req;
    logic                  bias;
    logic                  fault;
    logic                  fpend;
    logic                  note;
    logic [NEXT-1:0]       ext_temp_compare_enables;
    logic [SMT_DW-1:0]     thr;
    logic [5:0]            devad;
    logic [31:0]           rdata;
  } smt_st_type;

  smt_st_type st_q, st_d;

  smt_ahb_req_type ahb_in;
  logic            wr_act;
  logic            rd_act;
  logic [11:0]     act_addr;
  logic [SMT_DW-1:0] mem_rd;
  logic            mem_we;

  // is this element one that a measure command may address
  function automatic logic smt_valid_el(input logic [5:0] e);
    smt_valid_el = (e <= SMT_EL_CELL12) ||
                   (e >= SMT_EL_ITEMP && e <= SMT_EL_REF);
  endfunction : smt_valid_el

  // is this element an external thermistor input
  function automatic logic smt_is_ext(input logic [5:0] e);
    smt_is_ext = (e >= SMT_EL_EXT1) && (e <= SMT_EL_EXT4);
  endfunction : smt_is_ext

  assign ahb_in = '{hsel: hsel, haddr: haddr, htrans: htrans,
                    hwrite: hwrite, hsize: hsize, hready: hready};

  smt_ahb u_ahb (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .ahb_in   (ahb_in),
    .wr_act   (wr_act),
    .rd_act   (rd_act),
    .act_addr (act_addr)
  );

  // result written on every conversion answer that arrives in WAIT
  // a stray done pulse outside WAIT is dropped, so a word is only
  // ever written for the element that was actually requested
  assign mem_we = (st_q.fsm == SMT_WAIT) && conv_done;

  // the read index comes from the address phase; the word leaves the
  // memory register in the data phase, which is what lets results
  // go out with no wait state
  smt_mem u_mem (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_en   (mem_we),
    .wr_addr (st_q.el[SMT_AW-1:0]),
    .wr_data (conv_data),
    .rd_addr (haddr[SMT_AW+1:2]),
    .rd_data (mem_rd)
  );

  // ************************************************************
  // sequencer and register file
  // ************************************************************
  // one process so that start, scan and fault all see one state copy
  always_comb begin
    logic [5:0] op;
    logic [5:0] sfx;
    logic [5:0] tgt;
    logic       ext_cmp;
    op      = hwdata[17:12];
    sfx     = hwdata[5:0];
    tgt     = hwdata[11:6];
    ext_cmp = 1'b0;
    st_d      = st_q;
    st_d.req  = 1'b0;
    st_d.note = 1'b0;

    // register writes; command ignored while a sequence runs
    // a write with the start bit clear is a no-op, so the word can be
    // rewritten without setting off a second run
    if (wr_act) begin
      case (act_addr)
        SMT_A_CMD: begin
          if (st_q.fsm == SMT_IDLE && hwdata[SMT_CMD_START]
              && tgt == st_q.devad) begin
            if (op == SMT_OP_MEASURE && smt_valid_el(sfx)) begin
              st_d.el   = sfx;
              st_d.last = sfx;
              st_d.scan = 1'b0;
              if (smt_is_ext(sfx)) begin
                st_d.bias = 1'b1;
                st_d.fsm  = SMT_SETTLE;
                st_d.cnt  = '0;
              end else begin
                st_d.fsm = SMT_START;
              end
            end else if (op == SMT_OP_TSCAN) begin
              st_d.el   = SMT_EL_ITEMP;
              st_d.last = SMT_EL_LOOP;
              st_d.scan = 1'b1;
              st_d.bias = 1'b1;
              st_d.fsm  = SMT_SETTLE;
              st_d.cnt  = '0;
            end
          end
        end
        SMT_A_CFG: st_d.ext_temp_compare_enables = hwdata[NEXT-1:0];
        SMT_A_THR: st_d.thr = hwdata[SMT_DW-1:0];
        SMT_A_DEVAD: st_d.devad = hwdata[5:0];
        // writing the fault bit back as one clears the fault pin
        SMT_A_STAT: begin
          if (hwdata[SMT_STAT_FAULT]) begin
            st_d.fault = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // sequencer
    case (st_q.fsm)
      SMT_IDLE: ;
      // settling dwell before the first conversion
      // the counter is cleared on entry, so every scan and external input
      // measure gets the full dwell, counted in whole clock cycles
      SMT_SETTLE: begin
        if (st_q.cnt == 23'(DWELL_CYC - 1)) begin
          st_d.fsm = SMT_START;
        end else begin
          st_d.cnt = st_q.cnt + 23'd1;
        end
      end
      SMT_START: begin
        st_d.req = 1'b1;
        st_d.fsm = SMT_WAIT;
      end
      SMT_WAIT: begin
        if (conv_done) begin
          // compare only inputs with their enable set
          if (smt_is_ext(st_q.el)) begin
            ext_cmp = st_q.ext_temp_compare_enables[
                        2'(st_q.el - SMT_EL_EXT1)];
          end
          if (ext_cmp && conv_data < st_q.thr) begin
            st_d.fpend = 1'b1;
          end
          st_d.fsm = SMT_NEXTEL;
        end
      end
      // walk the inputs one after another
      // the bias drops in the step that ends the run, never later
      SMT_NEXTEL: begin
        if (st_q.el == st_q.last) begin
          st_d.fsm  = SMT_DONE;
          st_d.bias = 1'b0;
        end else begin
          st_d.el  = st_q.el + 6'd1;
          st_d.fsm = SMT_START;
        end
      end
      // report the fault at the end, then back to standby
      // the set comes after the register decode, so a software clear
      // in this same cycle loses and the fault is not missed
      SMT_DONE: begin
        if (st_q.fpend) begin
          st_d.fault = 1'b1;
          st_d.note  = 1'b1;
        end
        st_d.fpend = 1'b0;
        st_d.fsm   = SMT_IDLE;
      end
      default: st_d.fsm = SMT_IDLE;
    endcase

    // read data for the next data phase; prepared from the address
    // phase and registered, so it stands for the whole data phase
    st_d.rdata = '0;
    if (hsel && hready && htrans == SMT_HT_NONSEQ && !hwrite
        && hsize == SMT_HS_WORD) begin
      case (haddr[11:0])
        SMT_A_STAT: begin
          st_d.rdata[SMT_STAT_BUSY]  = (st_q.fsm != SMT_IDLE);
          st_d.rdata[SMT_STAT_FAULT] = st_q.fault;
          st_d.rdata[SMT_STAT_BIAS]  = st_q.bias;
        end
        SMT_A_CFG:   st_d.rdata[NEXT-1:0] = st_q.ext_temp_compare_enables;
        SMT_A_THR:   st_d.rdata[SMT_DW-1:0] = st_q.thr;
        SMT_A_DEVAD: st_d.rdata[5:0] = st_q.devad;
        default: ;
      endcase
    end
  end

  // state register; compare enables clear at reset
  // the whole state is one word, so reset and update cannot drift
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{fsm: SMT_IDLE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // result words come straight out of the memory register
  always_comb begin
    hrdata = st_q.rdata;
    if (rd_act && act_addr >= SMT_A_RES && act_addr <= SMT_A_RESEND) begin
      hrdata = {18'h00000, mem_rd};
    end
  end

  // no wait states: every access completes in its own data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign conv_req  = st_q.req;
  assign conv_sel  = st_q.el;
  assign thermistor_bias_output = st_q.bias;
  // pull-ups on while the bias runs, so open inputs read full scale
  assign ext_pullup_en = {NEXT{st_q.bias}};
  // fault pin and notice come straight from flip-flops, glitch free
  assign fault_out  = st_q.fault;
  assign fault_note = st_q.note;

endmodule : smt_top
`default_nettype wire

// file: smt_conv_model.sv
/*
 * smt_conv_model: behavioural converter front end facing the sequencer.
 * assumes: one done pulse per request, latency and data base set by bench.
 */
`default_nettype none
module smt_conv_model
  import smt_pkg::*;
(
  input  wire logic              clk_sys,   // system clock
  input  wire logic              sys_rst,   // async reset, high
  input  wire logic              conv_req,  // start request
  input  wire logic [5:0]        conv_sel,  // element selected
  input  wire logic [7:0]        base,      // low byte of the result
  input  wire logic [2:0]        lat,       // extra cycles to answer
  output logic                   conv_done, // result strobe
  output logic      [SMT_DW-1:0] conv_data  // result word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy;
  logic [2:0] cnt;
  logic [5:0] sel;

  // data toggles off the strobe so a stale word never looks valid
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= '0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_req) begin
        busy <= 1'b1;
        cnt <= lat;
        sel <= conv_sel;
      end else if (busy && cnt == 3'h0) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= {sel, base};
      end else if (busy) begin
        cnt <= cnt - 3'h1;
      end
    end
  end
endmodule : smt_conv_model
`default_nettype wire

// file: smt_top_monitor.sv
/*
 * smt_top_monitor: concurrent checks on the sequencer's ports.
 * assumes: bound into smt_top, one clock domain.
 */
`default_nettype none
module smt_top_monitor
  import smt_pkg::*;
#(
  parameter int DWELL_CYC = SMT_DWELL_CYC, // settling dwell in cycles
  parameter int NEXT      = SMT_NEXT       // external inputs
) (
  input  wire logic            clk_sys,   // clock
  input  wire logic            sys_rst,   // reset
  input  wire logic            hsel,      // select
  input  wire logic [31:0]     haddr,     // address
  input  wire logic [1:0]      htrans,    // transfer type
  input  wire logic            hwrite,    // write
  input  wire logic            hready,    // bus ready
  input  wire logic [31:0]     hwdata,    // write data
  input  wire logic            conv_req,  // conversion start
  input  wire logic [5:0]      conv_sel,  // mux selection
  input  wire logic            conv_done, // conversion done
  input  wire logic            thermistor_bias_output, // bias
  input  wire logic [NEXT-1:0] ext_pullup_en, // pull-ups
  input  wire logic            fault_out, // fault pin
  input  wire logic            fault_note // notify pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLO = DWELL_CYC - 1;
  localparam int DHI = DWELL_CYC + 2;
  logic        wr_stat_q;
  logic        bias_q;   // bias as seen one cycle ago
  logic        dw_run_q; // bias up, first request not yet seen
  logic [23:0] dw_q;     // cycles since the bias came up

  // ************************************************************
  // helper: a status write is in its data phase
  // ************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) wr_stat_q <= 1'b0;
    else wr_stat_q <= hsel && hready && htrans == SMT_HT_NONSEQ &&
                      hwrite && haddr[11:0] == SMT_A_STAT;
  end

  // helper: dwell counter, from bias rising to the first request;
  // a counter, since the real dwell is far beyond any delay range
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bias_q   <= 1'b0;
      dw_run_q <= 1'b0;
      dw_q     <= '0;
    end else begin
      bias_q <= thermistor_bias_output;
      if (thermistor_bias_output && !bias_q) begin
        dw_run_q <= 1'b1;
        dw_q     <= '0;
      end else if (conv_req) begin
        dw_run_q <= 1'b0;
      end else if (dw_run_q) begin
        dw_q <= dw_q + 24'h000001;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_first_req;
    conv_req && dw_run_q;
  endsequence
  sequence s_dwell_done;
    dw_q >= DLO && dw_q <= DHI;
  endsequence

  a_dwell_range: assert property (s_first_req |-> s_dwell_done)
    else $error("first conversion not after the dwell");
  a_dwell_bound: assert property (dw_run_q |-> dw_q <= DHI)
    else $error("no conversion after the dwell");
  a_req_pulse: assert property (conv_req |=> !conv_req)
    else $error("conversion request longer than one cycle");
  a_pull_bias: assert property (
    ext_pullup_en == {NEXT{thermistor_bias_output}})
    else $error("pull-ups differ from bias state");
  a_ext_bias: assert property (
    conv_req && conv_sel inside {[SMT_EL_EXT1:SMT_EL_EXT4]}
    |-> thermistor_bias_output)
    else $error("external input converted without bias");
  a_cell_nobias: assert property (
    conv_req && conv_sel <= SMT_EL_CELL12 |-> !thermistor_bias_output)
    else $error("bias on for a voltage measure");
  a_bias_end: assert property (
    conv_done && conv_sel == SMT_EL_LOOP && thermistor_bias_output
    |-> ##[1:3] !thermistor_bias_output)
    else $error("bias not off after last conversion");
  a_bias_fall: assert property ($fell(thermistor_bias_output)
    |-> $past(conv_done) || $past(conv_done, 2))
    else $error("bias off without a finished conversion");
  a_fault_after: assert property (fault_note |-> fault_out &&
    !$past(thermistor_bias_output) && $past(thermistor_bias_output, 2))
    else $error("fault notice not at end of scan");
  a_note_pulse: assert property (fault_note |=> !fault_note)
    else $error("fault notice longer than one cycle");
  a_fault_sticky: assert property ($fell(fault_out)
    |-> $past(wr_stat_q) && $past(hwdata[SMT_STAT_FAULT]))
    else $error("fault pin cleared without a status write");
endmodule : smt_top_monitor

bind smt_top smt_top_monitor #(.DWELL_CYC(DWELL_CYC), .NEXT(NEXT)) mon_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .conv_req(conv_req), .conv_sel(conv_sel), .conv_done(conv_done),
  .thermistor_bias_output(thermistor_bias_output),
  .ext_pullup_en(ext_pullup_en), .fault_out(fault_out),
  .fault_note(fault_note));
`default_nettype wire

// file: smt_top_tb.sv
/*
 * smt_top_tb: self-checking bench for the measure and scan sequencer.
 * assumes: smt_pkg, smt_top and the converter model are compiled first.
 */
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module smt_top_tb
  import smt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DWS = 20; // short dwell keeps the run brief
  logic clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, prev, seed = 32'hA0692CBE;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = SMT_HS_WORD, lat = 3'h0;
  logic [7:0] base = 8'h00;
  logic [5:0] dev, sfx, mlist [9];
  logic [3:0] cfg;
  logic [13:0] thr;
  logic hreadyout, hresp, conv_req, conv_done, bias, fault_out, fault_note;
  logic [5:0] conv_sel;
  logic [13:0] conv_data;
  logic [3:0] pull;
  int n_errors = 0, n_compared = 0, n_note = 0, k, j;

  smt_top #(.DWELL_CYC(DWS), .NEXT(SMT_NEXT)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .conv_req(conv_req), .conv_sel(conv_sel),
    .conv_done(conv_done), .conv_data(conv_data),
    .thermistor_bias_output(bias), .ext_pullup_en(pull),
    .fault_out(fault_out), .fault_note(fault_note));
  smt_conv_model conv_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .conv_req(conv_req), .conv_sel(conv_sel), .base(base), .lat(lat),
    .conv_done(conv_done), .conv_data(conv_data));

  always #12.5 clk_sys = ~clk_sys;
  // notice pulses counted so each scan can be judged afterwards
  always @(posedge clk_sys) if (fault_note === 1'b1) n_note++;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] cmd_w(input logic [5:0] op, dv, el);
    return (32'h1 << SMT_CMD_START) | {14'h0, op, dv, el};
  endfunction : cmd_w
  // an enabled input whose word is below the threshold faults
  function automatic logic exp_fault(input logic [3:0] en,
      input logic [13:0] th, input logic [7:0] b);
    logic f;
    f = 1'b0;
    for (int i = 0; i < 4; i++)
      if (en[i] && {SMT_EL_EXT1 + 6'(i), b} < th) f = 1'b1;
    return f;
  endfunction : exp_fault

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic ahb(input logic w, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= SMT_HT_NONSEQ;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  // start a command with fresh random data, then poll busy
  task automatic run(input logic [5:0] op, dv, el);
    logic [31:0] r;
    seed = lfsr(seed);
    base <= seed[7:0];
    lat <= seed[10:8];
    ahb(1'b1, SMT_A_CMD, cmd_w(op, dv, el), r);
    for (int i = 0; i < 300; i++) begin
      ahb(1'b0, SMT_A_STAT, '0, r);
      if (r[SMT_STAT_BUSY] === 1'b0) break;
    end
    repeat (3) @(posedge clk_sys);
  endtask : run
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    test_done;
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    mlist = '{6'h00, 6'h01, 6'h0C, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14,
              6'h15};
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    ahb(1'b0, SMT_A_CFG, '0, rd);
    `CHK("cfg reset", 32'h0, rd)
    ahb(1'b0, 12'h200, '0, rd);
    `CHK("unmapped", 32'h0, rd)
    seed = lfsr(seed);
    dev = seed[5:0] | 6'h01;
    ahb(1'b1, SMT_A_DEVAD, {26'h0, dev}, rd);
    for (k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      sfx = (k < 9) ? mlist[k] : 6'(seed[3:0] % 12 + 1);
      run(SMT_OP_MEASURE, dev, sfx);
      ahb(1'b0, SMT_A_STAT, '0, rd);
      `CHK("idle", 1'b0, rd[SMT_STAT_BUSY])
      `CHK("bias off", 1'b0, bias)
      ahb(1'b0, SMT_A_RES + 12'(4 * sfx), '0, rd);
      `CHK("result", {18'h0, sfx, base}, rd)
    end
    // a foreign device address must leave the stored word alone
    prev = {18'h0, sfx, base};
    run(SMT_OP_MEASURE, dev ^ 6'h01, sfx);
    ahb(1'b0, SMT_A_RES + 12'(4 * sfx), '0, rd);
    `CHK("other device", prev, rd)
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      cfg = (k == 0) ? 4'h1 : (k == 1) ? 4'h0 : seed[3:0];
      thr = (k < 2) ? 14'h3FFF : {2'b01, seed[15:4]};
      ahb(1'b1, SMT_A_CFG, {28'h0, cfg}, rd);
      ahb(1'b1, SMT_A_THR, {18'h0, thr}, rd);
      j = n_note;
      run(SMT_OP_TSCAN, dev, 6'h00);
      `CHK("fault pin", exp_fault(cfg, thr, base), fault_out)
      `CHK("notices", int'(exp_fault(cfg, thr, base)), n_note - j)
      for (int e = 16; e < 24; e++) begin
        ahb(1'b0, SMT_A_RES + 12'(4 * e), '0, rd);
        `CHK("scan word", {18'h0, 6'(e), base}, rd)
      end
      ahb(1'b1, SMT_A_STAT, 32'h2, rd);
      repeat (2) @(posedge clk_sys);
      `CHK("fault cleared", 1'b0, fault_out)
    end
    test_done;
  end
endmodule : smt_top_tb
`undef CHK
`default_nettype wire
